/* hdl/banked_data_memory_decoder.sv */
`timescale 1ns/10ps
`default_nettype none

module banked_data_memory_decoder
  import bank_decode_pkg::*;
(
  input  wire logic              CORE_CLK,
  input  wire logic              RST,
  input  wire logic              BANK_WE,
  input  wire logic [BANK_W-1:0] BANK_WDATA,
  input  wire logic              ACC_VALID,
  input  wire logic              ACC_INDIRECT,
  input  wire logic [OFS_W-1:0]  ACC_OFFSET,
  input  wire logic [ADDR_W-1:0] ACC_ADDR,
  input  wire logic              ACC_WRITE,
  input  wire logic [DATA_W-1:0] ACC_WDATA,
  output logic [BANK_W-1:0]      ACTIVE_BANK,
  output logic                   RESP_VALID,
  output logic [2:0]             RESP_REGION,
  output logic [BANK_W-1:0]      RESP_BANK,
  output logic [OFS_W-1:0]       RESP_OFFSET,
  output logic [OFS_W-1:0]       RESP_PERIPH_INDEX,
  output logic [ADDR_W-1:0]      RESP_GPR_INDEX,
  output logic [DATA_W-1:0]      RESP_RDATA
);

  // layout of every bank, by offset:
  //   core registers first, the same in each bank
  //   then the peripheral area, twenty or a hundred bytes by bank
  //   then up to eighty general bytes in the smaller banks
  //   the last sixteen offsets land in the shared store
  // the larger banks have no general bytes: their peripheral area
  // reaches right up to the shared store
  // core, peripheral and general bytes are not stored here and read zero
  // a pointer access names bank and offset itself, in thirteen bits
  // a direct access takes its bank from the bank select register

  // link to the shared byte store; this module drives its write side
  common_ram_if cram ();  // link to the common ram store

  // bank select state
  // written by the core, read by every direct access
  logic [BANK_W-1:0] bank_q;  // bank_select_register contents
  logic [BANK_W-1:0] bank_d;

  // response state: every field but the valid pulse loads on an access and holds until the next
  // one-cycle pulse per access
  logic              valid_q;
  logic              valid_d;
  // region the access fell into
  region_t           region_q;
  region_t           region_d;
  // bank the access landed in
  logic [BANK_W-1:0] rbank_q;
  logic [BANK_W-1:0] rbank_d;
  // offset inside that bank
  logic [OFS_W-1:0]  rofs_q;
  logic [OFS_W-1:0]  rofs_d;
  // core register number or peripheral index
  logic [OFS_W-1:0]  pidx_q;
  logic [OFS_W-1:0]  pidx_d;
  // linear index of a general byte
  logic [ADDR_W-1:0] gidx_q;
  logic [ADDR_W-1:0] gidx_d;
  // read data of the shared store
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // address of the current access
  logic [BANK_W-1:0] acc_bank;  // bank the access lands in
  logic [OFS_W-1:0]  acc_ofs;   // offset inside that bank
  // region decoded from bank and offset
  region_t           acc_region;

  // split the address: pointer carries its own bank, direct uses the register
  // the selected bank never reaches a pointer access
  always_comb begin
    if (ACC_INDIRECT) begin
      // pointer: upper six bits pick the bank, lower seven the offset
      acc_bank = ACC_ADDR[ADDR_W-1:OFS_W];
      acc_ofs  = ACC_ADDR[OFS_W-1:0];
    end else begin
      // direct: bank select register plus the offset of the instruction
      acc_bank = bank_q;
      acc_ofs  = ACC_OFFSET;
    end
    // one decode serves both kinds of access
    acc_region = decode_region(acc_bank, acc_ofs);
  end

  // common ram is addressed by the low offset bits only, whatever the bank
  // so a write made through one bank is read back through every other
  always_comb begin
    cram.idx   = acc_ofs[CRAM_W-1:0];
    // write data passes straight through
    cram.wdata = ACC_WDATA;
    // only accepted writes that land in the shared offsets store a byte
    cram.we    = ACC_VALID && ACC_WRITE && (acc_region == REG_COMMON);
  end

  // next bank select value
  always_comb begin
    // keep the bank unless the core writes a new one
    bank_d = bank_q;
    if (BANK_WE) begin
      // an access in this same cycle still decodes with the old bank
      bank_d = BANK_WDATA;
    end
  end

  // bank select register, cleared by reset
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      bank_q <= BANK_RESET;
    end else begin
      bank_q <= bank_d;
    end
  end

  // next response values
  // fields hold between accesses so they stand until the next one
  always_comb begin
    valid_d  = ACC_VALID;
    region_d = region_q;
    rbank_d  = rbank_q;
    rofs_d   = rofs_q;
    pidx_d   = pidx_q;
    gidx_d   = gidx_q;
    rdata_d  = rdata_q;
    // an accepted access loads every field
    if (ACC_VALID) begin
      region_d = acc_region;
      rbank_d  = acc_bank;
      rofs_d   = acc_ofs;
      // clear what this region does not use
      pidx_d   = {OFS_W{1'b0}};
      gidx_d   = INDEX_ZERO;
      rdata_d  = DATA_ZERO;  // unimplemented and elsewhere-held bytes read zero
      unique case (acc_region)
        // core registers live in the core; same in every bank
        REG_CORE: begin
          // peripheral index carries the core register number
          pidx_d = acc_ofs;
        end
        // index inside the peripheral area
        REG_PERIPH: begin
          // counted from the end of the core registers
          pidx_d = acc_ofs - CORE_COUNT;
        end
        // linear general purpose byte
        REG_GPR: begin
          // eighty bytes per bank, laid end to end
          gidx_d = gpr_index(acc_bank, acc_ofs);
        end
        // shared bytes, old value when written in the same cycle
        REG_COMMON: begin
          // a write this cycle shows on the next read
          rdata_d = cram.rdata;
        end
        // gap between general bytes and common ram
        REG_NONE: begin
          // only reachable if the area sizes change
          rdata_d = DATA_ZERO;
        end
      endcase
    end
  end

  // response registers; reset shows no access, region unimplemented
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      valid_q  <= 1'b0;
      region_q <= REG_NONE;
      rbank_q  <= BANK_RESET;
      rofs_q   <= {OFS_W{1'b0}};
      pidx_q   <= {OFS_W{1'b0}};
      gidx_q   <= INDEX_ZERO;
      rdata_q  <= DATA_ZERO;
    end else begin
      // load the next values
      valid_q  <= valid_d;
      region_q <= region_d;
      rbank_q  <= rbank_d;
      rofs_q   <= rofs_d;
      pidx_q   <= pidx_d;
      gidx_q   <= gidx_d;
      rdata_q  <= rdata_d;
    end
  end

  // shared byte store
  // one physical store behind offsets 70h-7Fh of every bank
  common_ram_store u_common (
    .clk (CORE_CLK),
    .rst (RST),
    .ram (cram.store)
  );

  // outputs straight from flops
  // bank select register contents
  assign ACTIVE_BANK       = bank_q;
  // response pulse and the fields that stand until the next access
  assign RESP_VALID        = valid_q;
  // region, bank, offset and indices of the last access
  assign RESP_REGION       = region_q;
  assign RESP_BANK         = rbank_q;
  assign RESP_OFFSET       = rofs_q;
  assign RESP_PERIPH_INDEX = pidx_q;
  assign RESP_GPR_INDEX    = gidx_q;
  assign RESP_RDATA        = rdata_q;

endmodule // banked_data_memory_decoder

`default_nettype wire

/* hdl/bank_decode_pkg.sv */
package bank_decode_pkg;

  // address widths
  localparam int BANK_W = 6;
  localparam int OFS_W  = 7;
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int CRAM_W = 4;

  // layout of one bank
  localparam logic [OFS_W-1:0] CORE_COUNT   = 7'h0C;  // core registers per bank
  localparam logic [OFS_W-1:0] PERIPH_SMALL = 7'h14;  // peripheral bytes, banks 0..59
  localparam logic [OFS_W-1:0] PERIPH_LARGE = 7'h64;  // peripheral bytes, banks 60..63
  localparam logic [OFS_W-1:0] GPR_MAX      = 7'h50;  // general purpose bytes per bank
  localparam logic [OFS_W-1:0] COMMON_BASE  = 7'h70;  // first common ram offset
  localparam int               COMMON_COUNT = 16;     // common ram bytes

  // first bank with the large peripheral area
  localparam logic [BANK_W-1:0] LARGE_BANK_FIRST = 6'h3C;

  // reset values
  localparam logic [BANK_W-1:0] BANK_RESET = 6'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;
  localparam logic [ADDR_W-1:0] INDEX_ZERO = 13'h0000;

  // region of an access
  typedef enum logic [2:0] {
    REG_CORE,
    REG_PERIPH,
    REG_GPR,
    REG_COMMON,
    REG_NONE
  } region_t;

  // size of the peripheral area of a bank
  function automatic logic [OFS_W-1:0] periph_size(input logic [BANK_W-1:0] bank);
    periph_size = (bank >= LARGE_BANK_FIRST) ? PERIPH_LARGE : PERIPH_SMALL;
  endfunction

  // first offset past the peripheral area
  function automatic logic [OFS_W-1:0] gpr_base(input logic [BANK_W-1:0] bank);
    gpr_base = CORE_COUNT + periph_size(bank);
  endfunction

  // region that a bank and offset fall into
  function automatic region_t decode_region(input logic [BANK_W-1:0] bank,
                                            input logic [OFS_W-1:0]  ofs);
    logic [OFS_W-1:0] base;
    logic [OFS_W:0]   gpr_end;
    base    = gpr_base(bank);
    gpr_end = {1'b0, base} + {1'b0, GPR_MAX};
    if (ofs < CORE_COUNT)
      decode_region = REG_CORE;
    else if (ofs < base)
      decode_region = REG_PERIPH;
    else if (ofs >= COMMON_BASE)
      decode_region = REG_COMMON;
    else if ({1'b0, ofs} < gpr_end)
      decode_region = REG_GPR;
    else
      decode_region = REG_NONE;
  endfunction

  // linear index of a general purpose byte over all banks
  function automatic logic [ADDR_W-1:0] gpr_index(input logic [BANK_W-1:0] bank,
                                                  input logic [OFS_W-1:0]  ofs);
    logic [ADDR_W-1:0] prod;
    logic [OFS_W-1:0]  rel;
    prod      = ADDR_W'(bank) * ADDR_W'(GPR_MAX);
    rel       = ofs - gpr_base(bank);
    gpr_index = prod + ADDR_W'(rel);
  endfunction

endpackage

/* hdl/common_ram_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface common_ram_if;
  import bank_decode_pkg::*;
  logic              we;     // write strobe
  logic [CRAM_W-1:0] idx;    // byte index
  logic [DATA_W-1:0] wdata;  // write data
  logic [DATA_W-1:0] rdata;  // read data at idx

  modport owner (output we, output idx, output wdata, input rdata);
  modport store (input we, input idx, input wdata, output rdata);
endinterface

`default_nettype wire

/* hdl/common_ram_store.sv */
`timescale 1ns/10ps
`default_nettype none

module common_ram_store
  import bank_decode_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  common_ram_if.store     ram
);

  logic [DATA_W-1:0] mem_q [COMMON_COUNT];  // shared bytes
  logic [DATA_W-1:0] mem_d [COMMON_COUNT];  // next contents

  // next contents: one byte per write
  always_comb begin
    for (int i = 0; i < COMMON_COUNT; i++) begin
      mem_d[i] = mem_q[i];
    end
    if (ram.we) begin
      mem_d[ram.idx] = ram.wdata;
    end
  end

  // storage flops, cleared on reset
  always_ff @(posedge clk) begin
    for (int i = 0; i < COMMON_COUNT; i++) begin
      if (rst) begin
        mem_q[i] <= DATA_ZERO;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  // read is combinational; the owner registers it
  assign ram.rdata = mem_q[ram.idx];

endmodule // common_ram_store

`default_nettype wire

/* test/bank_decode_sva.sv */
`timescale 1ns/10ps
`default_nettype none

module bank_decode_sva
  import bank_decode_pkg::*;
(
  input wire logic              CORE_CLK,
  input wire logic              RST,
  input wire logic              BANK_WE,
  input wire logic [BANK_W-1:0] BANK_WDATA,
  input wire logic              ACC_VALID,
  input wire logic              ACC_INDIRECT,
  input wire logic [OFS_W-1:0]  ACC_OFFSET,
  input wire logic [ADDR_W-1:0] ACC_ADDR,
  input wire logic              ACC_WRITE,
  input wire logic [DATA_W-1:0] ACC_WDATA,
  input wire logic [BANK_W-1:0] ACTIVE_BANK,
  input wire logic              RESP_VALID,
  input wire logic [2:0]        RESP_REGION,
  input wire logic [BANK_W-1:0] RESP_BANK,
  input wire logic [OFS_W-1:0]  RESP_OFFSET,
  input wire logic [OFS_W-1:0]  RESP_PERIPH_INDEX,
  input wire logic [ADDR_W-1:0] RESP_GPR_INDEX,
  input wire logic [DATA_W-1:0] RESP_RDATA
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // direct access in flight
  wire logic dir = ACC_VALID && !ACC_INDIRECT;

  chk_resp_pulse: assert property (ACC_VALID |=> RESP_VALID)
    else $error("response pulse missing");
  chk_no_extra: assert property (!ACC_VALID |=> !RESP_VALID)
    else $error("response without access");
  chk_bank_load: assert property (BANK_WE |=> ACTIVE_BANK == $past(BANK_WDATA))
    else $error("bank not loaded");
  chk_bank_keep: assert property (!BANK_WE |=> $stable(ACTIVE_BANK))
    else $error("bank changed on its own");
  chk_core_map: assert property (dir && ACC_OFFSET < CORE_COUNT |=>
    RESP_REGION == 3'h0 && RESP_PERIPH_INDEX == $past(ACC_OFFSET)) else $error("core map");
  chk_common_map: assert property (dir && ACC_OFFSET >= COMMON_BASE |=> RESP_REGION == 3'h3)
    else $error("common map");
  chk_direct_bank: assert property (dir |=> RESP_BANK == $past(ACTIVE_BANK))
    else $error("direct access used wrong bank");
  chk_ptr_addr: assert property (ACC_VALID && ACC_INDIRECT |=>
    {RESP_BANK, RESP_OFFSET} == $past(ACC_ADDR)) else $error("pointer address split");
  chk_big_periph: assert property (dir && ACTIVE_BANK >= LARGE_BANK_FIRST &&
    ACC_OFFSET >= CORE_COUNT && ACC_OFFSET < COMMON_BASE |=> RESP_REGION == 3'h1)
    else $error("large peripheral area");
  chk_small_periph: assert property (dir && ACTIVE_BANK < LARGE_BANK_FIRST &&
    ACC_OFFSET >= CORE_COUNT && ACC_OFFSET < CORE_COUNT + PERIPH_SMALL |=> RESP_REGION == 3'h1)
    else $error("small peripheral area");

  // main scenarios
  cover property (dir && ACC_WRITE && ACC_OFFSET >= COMMON_BASE);
  cover property (ACC_VALID && ACC_INDIRECT);
  cover property (BANK_WE && dir);
endmodule // bank_decode_sva

bind banked_data_memory_decoder bank_decode_sva bank_decode_sva_i (.*);

`default_nettype wire

/* test/core_model.sv */
`timescale 1ns/10ps
`default_nettype none

// core side: issues one access, optionally with a bank write alongside
module core_model
  import bank_decode_pkg::*;
(
  input  wire logic         clk,
  output logic              we,
  output logic [BANK_W-1:0] wb,
  output logic              v,
  output logic              ind,
  output logic [OFS_W-1:0]  ofs,
  output logic [ADDR_W-1:0] adr,
  output logic              wr,
  output logic [DATA_W-1:0] wd
);
  initial {we, wb, v, ind, ofs, adr, wr, wd} = '0;

  // drive after an edge, hold through the taking edge, then release
  task automatic go(input logic b, input logic [5:0] bd, input logic i,
                    input logic [6:0] o, input logic [12:0] a, input logic w,
                    input logic [7:0] d);
    @(posedge clk);
    we <= b;
    wb <= bd;
    v <= 1'b1;
    ind <= i;
    ofs <= o;
    adr <= a;
    wr <= w;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
    v <= 1'b0;
    ofs <= ~o; // released lines do not keep old value
    adr <= ~a;
    wd <= ~d;
    #1;
  endtask
endmodule // core_model

`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import bank_decode_pkg::*;
  logic CORE_CLK = 1'b0;
  logic RST = 1'b1;
  logic we, v, ind, wr, rv;
  logic [5:0] wb, ab, rb;
  logic [6:0] ofs, ro, rp;
  logic [12:0] adr, rg;
  logic [7:0] wd, rd;
  logic [2:0] rr;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  always #5 CORE_CLK = ~CORE_CLK;

  core_model core_model_i (.clk(CORE_CLK), .we(we), .wb(wb), .v(v), .ind(ind),
    .ofs(ofs), .adr(adr), .wr(wr), .wd(wd));
  banked_data_memory_decoder banked_data_memory_decoder_i (.CORE_CLK(CORE_CLK),
    .RST(RST), .BANK_WE(we), .BANK_WDATA(wb), .ACC_VALID(v), .ACC_INDIRECT(ind),
    .ACC_OFFSET(ofs), .ACC_ADDR(adr), .ACC_WRITE(wr), .ACC_WDATA(wd),
    .ACTIVE_BANK(ab), .RESP_VALID(rv), .RESP_REGION(rr), .RESP_BANK(rb),
    .RESP_OFFSET(ro), .RESP_PERIPH_INDEX(rp), .RESP_GPR_INDEX(rg), .RESP_RDATA(rd));

  task automatic conclude;
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  // expected region from bank and offset
  function automatic logic [2:0] exp_reg(input int b, input int o);
    if (o < 12) return 3'h0;
    if (o >= 112) return 3'h3;
    if (b >= 60 || o < 32) return 3'h1;
    return 3'h2;
  endfunction

  // boundaries of every region in small and large banks
  task automatic t_map;
    int bk[4] = '{0, 59, 60, 63};
    int of[8] = '{0, 11, 12, 31, 32, 111, 112, 127};
    logic [2:0] r;
    foreach (bk[i]) begin
      core_model_i.go(1'b1, 6'(bk[i]), 1'b0, 7'h00, 13'h0000, 1'b0, 8'h00);
      foreach (of[j]) begin
        core_model_i.go(1'b0, 6'h00, 1'b0, 7'(of[j]), 13'h0000, 1'b0, 8'h00);
        r = exp_reg(bk[i], of[j]);
        check(rv, 1);
        check(ro, of[j]);
        check(rd, 8'h00);
        check(rb, bk[i]);
        check(rr, r);
        check(rp, r == 0 ? of[j] : r == 1 ? of[j] - 12 : 0);
        check(rg, r == 2 ? bk[i] * 80 + of[j] - 32 : 0);
      end
    end
  endtask

  // one shared store written through bank 3, read back through bank 3Eh and through the pointer
  task automatic t_common;
    core_model_i.go(1'b1, 6'h03, 1'b0, 7'h00, 13'h0000, 1'b0, 8'h00);
    core_model_i.go(1'b0, 6'h00, 1'b0, 7'h75, 13'h0000, 1'b1, 8'hA5);
    check(rd, 8'h00);
    core_model_i.go(1'b1, 6'h3E, 1'b0, 7'h7F, 13'h0000, 1'b1, 8'h5A);
    core_model_i.go(1'b0, 6'h00, 1'b0, 7'h75, 13'h0000, 1'b0, 8'h00);
    check(rd, 8'hA5);
    core_model_i.go(1'b0, 6'h00, 1'b1, 7'h00, 13'h147F, 1'b0, 8'h00);
    check(rd, 8'h5A);
  endtask

  // pointer access ignores the selected bank
  task automatic t_indirect;
    core_model_i.go(1'b0, 6'h00, 1'b1, 7'h00, {6'h2A, 7'h45}, 1'b0, 8'h00);
    check(rb, 6'h2A);
    check(rr, 3'h2);
    check(rg, 42 * 80 + 69 - 32);
    check(ab, 6'h3E);
  endtask

  // same-cycle bank write leaves the access on the old bank
  task automatic t_old_bank;
    core_model_i.go(1'b1, 6'h01, 1'b0, 7'h00, 13'h0000, 1'b0, 8'h00);
    core_model_i.go(1'b1, 6'h3D, 1'b0, 7'h20, 13'h0000, 1'b0, 8'h00);
    check(rb, 6'h01);
    check(ab, 6'h3D);
    @(posedge CORE_CLK);
    #1;
    check(rv, 0);
  endtask

  // reset in mid-run clears the bank and the shared store
  task automatic t_reset;
    @(posedge CORE_CLK);
    RST <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    #1;
    check(ab, 6'h00);
    check(rv, 1'b0);
    check(rr, 3'h4);
    core_model_i.go(1'b0, 6'h00, 1'b0, 7'h75, 13'h0000, 1'b0, 8'h00);
    check(rr, 3'h3);
    check(rd, 8'h00);
  endtask

  // cut a hang short
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      conclude;
    end
  end

  initial begin
    repeat (5) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    #1;
    check(ab, 0);
    check(rv, 0);
    check(rr, 4);
    check(rd, 0);
    t_map;
    t_common;
    t_indirect;
    t_old_bank;
    t_reset;
    conclude;
  end
endmodule // testbench

`default_nettype wire
